// file: verilog/cfef_consts.svh
`ifndef CFEF_CONSTS_SVH
`define CFEF_CONSTS_SVH
// ==========================================================
// Register offsets (page 0)
`define CFEF_OFS_SHORT   7'h5f
`define CFEF_OFS_STICKY  7'h60
`define CFEF_OFS_LIVE    7'h61
`define CFEF_OFS_BTNCLR  7'h0e
// ==========================================================
// Bit positions
`define CFEF_B_LEFT_SC   7
`define CFEF_B_RIGHT_SC  6
`define CFEF_B_COM_SC    5
`define CFEF_B_RSVD      4
`define CFEF_B_COM_PWR   3
`define CFEF_B_BUTTON    3
`define CFEF_B_HEADSET   2
`define CFEF_B_NG_LEFT   1
`define CFEF_B_NG_RIGHT  0
// ==========================================================
// Reset values and timing
`define CFEF_RST_BYTE    8'h00
`define CFEF_PULSE_ON    4'h4
`define CFEF_PULSE_PER   4'h8
`endif

// file: verilog/cfef_pkg.sv
`default_nettype none
package cfef_pkg;
  typedef struct packed {
    logic left_sc;
    logic right_sc;
    logic com_sc;
    logic com_pwr;
    logic button;
    logic headset;
    logic ng_left;
    logic ng_right;
  } cfef_cond_s;
  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
  } cfef_rd_s;
endpackage : cfef_pkg
`default_nettype wire

// file: verilog/cfef_repeat_pulse.sv
`include "cfef_consts.svh"
`default_nettype none
module cfef_repeat_pulse
  import cfef_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pending,
  output var  logic pulse_out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       out;
  } cfef_rp_s;
  cfef_rp_s st_reg;
  cfef_rp_s st_next;
  // ==========================================================
  // Repeating pulse train while events are pending
  always_comb begin
    st_next = st_reg;
    if (!pending) begin
      st_next.cnt = 4'h0;
      st_next.out = 1'b0;
    end else begin
      st_next.cnt = (st_reg.cnt == `CFEF_PULSE_PER - 4'h1) ? 4'h0 : st_reg.cnt + 4'h1;
      st_next.out = (st_next.cnt < `CFEF_PULSE_ON);  // RULE_10
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign pulse_out = st_reg.out;
endmodule : cfef_repeat_pulse
`default_nettype wire

// file: verilog/cfef_event_flags.sv
// How it works
// RULE_01: Short status bits 7..5 show live short on left, right, common drivers.
// RULE_02: Short status bit 3 shows common driver fully powered up.
// RULE_03: Sticky bits 7..5 hold shorts, bit 3 holds button press.
// RULE_04: Sticky bit 2 sets on headset insertion or removal.
// RULE_05: Live flags register mirrors sticky layout with current states.
// RULE_06: Live bit 2 is one while a headset is present.
// RULE_07: Live button bit is sticky, cleared only by reading register 14.
// RULE_08: Bits 1 and 0 are one while channel power is below noise gate.
// RULE_09: Reserved bits read zero; host must not write them.
// RULE_10: Repeat mode pulses interrupt until sticky register is read.
// RULE_11: All flags reset to zero; writes never change them.
`include "cfef_consts.svh"
`default_nettype none
module cfef_event_flags
  import cfef_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire cfef_cond_s cond_in,
  input  wire logic       irq_repeat,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [6:0] reg_addr,
  output logic [7:0]      reg_rdata,
  output logic            irq_pulse
);
  typedef struct packed {
    cfef_cond_s live;
    cfef_cond_s prev;
    cfef_cond_s sticky;
    logic       live_btn;
    logic [7:0] rdata;
    logic       irq;
  } cfef_st_s;
  cfef_st_s st_reg;
  cfef_st_s st_next;
  logic     rep_out;
  logic     pending;
  function automatic logic [7:0] pack_flags(input cfef_cond_s c, input logic btn);
    pack_flags = {c.left_sc, c.right_sc, c.com_sc, 1'b0, btn, c.headset, c.ng_left, c.ng_right};
  endfunction : pack_flags
  // Strobe decode shared by both clearing reads
  function automatic logic rd_hit(input logic rd, input logic [6:0] a, input logic [6:0] ofs);
    rd_hit = rd && (a == ofs);
  endfunction : rd_hit
  // ==========================================================
  // Flag update; a new event wins over a clearing read
  always_comb begin
    st_next      = st_reg;
    st_next.live = cond_in;
    st_next.prev = st_reg.live;
    if (rd_hit(reg_rd, reg_addr, `CFEF_OFS_STICKY)) begin
      st_next.sticky = '0;  // RULE_10
    end
    if (rd_hit(reg_rd, reg_addr, `CFEF_OFS_BTNCLR)) begin
      st_next.live_btn = 1'b0;  // RULE_07
    end
    st_next.sticky.left_sc  = st_next.sticky.left_sc | st_reg.live.left_sc;   // RULE_03
    st_next.sticky.right_sc = st_next.sticky.right_sc | st_reg.live.right_sc; // RULE_03
    st_next.sticky.com_sc   = st_next.sticky.com_sc | st_reg.live.com_sc;     // RULE_03
    st_next.sticky.button   = st_next.sticky.button | st_reg.live.button;     // RULE_03
    st_next.sticky.headset  = st_next.sticky.headset
                            | (st_reg.live.headset ^ st_reg.prev.headset);    // RULE_04
    st_next.sticky.ng_left  = st_next.sticky.ng_left | st_reg.live.ng_left;   // RULE_08
    st_next.sticky.ng_right = st_next.sticky.ng_right | st_reg.live.ng_right; // RULE_08
    st_next.sticky.com_pwr  = 1'b0;
    st_next.live_btn        = st_next.live_btn | st_reg.live.button;          // RULE_07
    st_next.irq             = rep_out;  // RULE_10
    // Writes are ignored: these registers are read-only
    unique case (reg_addr)
      `CFEF_OFS_SHORT:  st_next.rdata = {st_reg.live.left_sc, st_reg.live.right_sc,
                                         st_reg.live.com_sc, 1'b0, st_reg.live.com_pwr,
                                         3'h0};  // RULE_01 RULE_02 RULE_09
      `CFEF_OFS_STICKY: st_next.rdata = pack_flags(st_reg.sticky, st_reg.sticky.button);
      `CFEF_OFS_LIVE:   st_next.rdata = pack_flags(st_reg.live, st_reg.live_btn); // RULE_05 RULE_06
      default:          st_next.rdata = `CFEF_RST_BYTE;
    endcase
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;  // RULE_11
    end else begin
      st_reg <= st_next;
    end
  end
  assign pending = irq_repeat && (st_reg.sticky != '0);
  cfef_repeat_pulse u_rep (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .pending   (pending),
    .pulse_out (rep_out)
  );
  // Pulse train passes through state so the pin comes straight from a flop
  assign reg_rdata = st_reg.rdata;
  assign irq_pulse = st_reg.irq;
  // ==========================================================
  // Checks
  property p_short_live;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_SHORT) |=> reg_rdata[7] == $past(st_reg.live.left_sc);
  endproperty
  a_short_live: assert property (p_short_live) else $error("short bit wrong"); // RULE_01
  property p_pwr;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_SHORT) |=> reg_rdata[3] == $past(st_reg.live.com_pwr);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit wrong"); // RULE_02
  property p_sticky_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    st_reg.sticky.left_sc && !(reg_rd && reg_addr == `CFEF_OFS_STICKY) |=> st_reg.sticky.left_sc;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky lost"); // RULE_03
  property p_hs_edge;
    @(posedge clk_sys) disable iff (sys_rst)
    (st_reg.live.headset != st_reg.prev.headset) |=> st_reg.sticky.headset;
  endproperty
  a_hs_edge: assert property (p_hs_edge) else $error("headset edge missed"); // RULE_04
  property p_live_hs;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_LIVE) |=> reg_rdata[2] == $past(st_reg.live.headset);
  endproperty
  a_live_hs: assert property (p_live_hs) else $error("live headset wrong"); // RULE_06
  property p_btn_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    st_reg.live_btn && !(reg_rd && reg_addr == `CFEF_OFS_BTNCLR) |=> st_reg.live_btn;
  endproperty
  a_btn_hold: assert property (p_btn_hold) else $error("button cleared early"); // RULE_07
  property p_rsvd;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rdata[`CFEF_B_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // RULE_09
  property p_irq;
    @(posedge clk_sys) disable iff (sys_rst)
    !pending [*2] |=> !irq_pulse;
  endproperty
  a_irq: assert property (p_irq) else $error("pulse without pending"); // RULE_10
  property p_ng;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_LIVE) |=> reg_rdata[0] == $past(st_reg.live.ng_right);
  endproperty
  a_ng: assert property (p_ng) else $error("noise gate wrong"); // RULE_08
  property p_wr;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_wr && !reg_rd && !st_reg.live.button |=> st_reg.live_btn == $past(st_reg.live_btn);
  endproperty
  a_wr: assert property (p_wr) else $error("write changed flag"); // RULE_11
  property p_short_right;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_SHORT) |=> reg_rdata[6] == $past(st_reg.live.right_sc);
  endproperty
  a_short_right: assert property (p_short_right) else $error("right short wrong"); // RULE_01
  property p_short_com;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_SHORT) |=> reg_rdata[5] == $past(st_reg.live.com_sc);
  endproperty
  a_short_com: assert property (p_short_com) else $error("common short wrong"); // RULE_01
  property p_short_low;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_SHORT) |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_short_low: assert property (p_short_low) else $error("short low bits set"); // RULE_09
  property p_btn_stk;
    @(posedge clk_sys) disable iff (sys_rst)
    st_reg.live.button |=> st_reg.sticky.button;
  endproperty
  a_btn_stk: assert property (p_btn_stk) else $error("button not captured"); // RULE_03
  property p_com_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    st_reg.sticky.com_sc && !rd_hit(reg_rd, reg_addr, `CFEF_OFS_STICKY)
    |=> st_reg.sticky.com_sc;
  endproperty
  a_com_hold: assert property (p_com_hold) else $error("common sticky lost"); // RULE_03
  property p_stk_hs;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_STICKY) |=> reg_rdata[2] == $past(st_reg.sticky.headset);
  endproperty
  a_stk_hs: assert property (p_stk_hs) else $error("sticky headset wrong"); // RULE_04
  property p_ack;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_hit(reg_rd, reg_addr, `CFEF_OFS_STICKY) && (st_reg.live == '0) && !st_reg.prev.headset
    |=> st_reg.sticky == '0;
  endproperty
  a_ack: assert property (p_ack) else $error("sticky read did not clear"); // RULE_10
  property p_btn_set;
    @(posedge clk_sys) disable iff (sys_rst)
    st_reg.live.button |=> st_reg.live_btn;
  endproperty
  a_btn_set: assert property (p_btn_set) else $error("live button not set"); // RULE_07
  property p_btn_clr;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_hit(reg_rd, reg_addr, `CFEF_OFS_BTNCLR) && !st_reg.live.button |=> !st_reg.live_btn;
  endproperty
  a_btn_clr: assert property (p_btn_clr) else $error("live button not cleared"); // RULE_07
  property p_live_com;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_LIVE) |=> reg_rdata[5] == $past(st_reg.live.com_sc);
  endproperty
  a_live_com: assert property (p_live_com) else $error("live common wrong"); // RULE_05
  property p_live_btn;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_LIVE) |=> reg_rdata[3] == $past(st_reg.live_btn);
  endproperty
  a_live_btn: assert property (p_live_btn) else $error("live button wrong"); // RULE_05
  property p_ng_left;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_addr == `CFEF_OFS_LIVE) |=> reg_rdata[1] == $past(st_reg.live.ng_left);
  endproperty
  a_ng_left: assert property (p_ng_left) else $error("left gate wrong"); // RULE_08
  property p_unmapped;
    @(posedge clk_sys) disable iff (sys_rst)
    !(reg_addr inside {`CFEF_OFS_SHORT, `CFEF_OFS_STICKY, `CFEF_OFS_LIVE})
    |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RULE_09
  property p_irq_start;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(pending) |-> ##[1:3] irq_pulse;
  endproperty
  a_irq_start: assert property (p_irq_start) else $error("pulse train late"); // RULE_10
  property p_wr_stk;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_wr && !reg_rd && (st_reg.live == '0) && !st_reg.prev.headset
    |=> st_reg.sticky == $past(st_reg.sticky);
  endproperty
  a_wr_stk: assert property (p_wr_stk) else $error("write changed sticky"); // RULE_11
endmodule : cfef_event_flags
`default_nettype wire

// file: test/cfef_testbench.sv
`include "cfef_consts.svh"
`default_nettype none
module testbench
  import cfef_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic       clk_sys;
  logic       sys_rst;
  cfef_cond_s cond_in;
  logic       irq_repeat;
  logic       reg_rd;
  logic       reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_rdata;
  logic       irq_pulse;
  int         num_errors;
  int         check_count;

  cfef_event_flags dut_u (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .cond_in   (cond_in),
    .irq_repeat(irq_repeat),
    .reg_rd    (reg_rd),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_rdata (reg_rdata),
    .irq_pulse (irq_pulse)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Peek without a read strobe so sticky state is left alone
  task automatic peek(input logic [6:0] a, input logic [7:0] exp, input string what);
    reg_addr = a;
    cyc(1);
    chk(what, reg_rdata, exp);
  endtask : peek

  // Extra cycles let the clear land before the next peek
  task automatic clr(input logic [6:0] a);
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc(1);
    reg_rd   = 1'b0;
    cyc(2);
  endtask : clr

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Scenarios
  task automatic t_shorts();
    cond_in = 8'hf3;
    cyc(3);
    peek(`CFEF_OFS_SHORT, 8'he8, "short");
    peek(`CFEF_OFS_LIVE, 8'he3, "live");
    peek(`CFEF_OFS_STICKY, 8'he3, "sticky");
    peek(7'h40, 8'h00, "unmapped");
    cond_in = 8'h00;
    cyc(3);
    peek(`CFEF_OFS_SHORT, 8'h00, "short");
    peek(`CFEF_OFS_LIVE, 8'h00, "live");
    peek(`CFEF_OFS_STICKY, 8'he3, "sticky");
    chk("irq idle", {7'h00, irq_pulse}, 8'h00);
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
    peek(`CFEF_OFS_STICKY, 8'he3, "wr");
    clr(`CFEF_OFS_STICKY);
    peek(`CFEF_OFS_STICKY, 8'h00, "ack");
  endtask : t_shorts

  task automatic t_button();
    cond_in = 8'h08;
    cyc(2);
    cond_in = 8'h00;
    cyc(3);
    peek(`CFEF_OFS_LIVE, 8'h08, "btn live");
    peek(`CFEF_OFS_STICKY, 8'h08, "btn stk");
    clr(`CFEF_OFS_STICKY);
    peek(`CFEF_OFS_LIVE, 8'h08, "btn hold");
    peek(`CFEF_OFS_STICKY, 8'h00, "btn ack");
    clr(`CFEF_OFS_BTNCLR);
    peek(`CFEF_OFS_LIVE, 8'h00, "btn clr");
  endtask : t_button

  task automatic t_headset();
    cond_in = 8'h04;
    cyc(3);
    peek(`CFEF_OFS_LIVE, 8'h04, "hs in");
    peek(`CFEF_OFS_STICKY, 8'h04, "hs ev");
    clr(`CFEF_OFS_STICKY);
    peek(`CFEF_OFS_STICKY, 8'h00, "hs ack");
    cond_in = 8'h00;
    cyc(3);
    peek(`CFEF_OFS_STICKY, 8'h04, "hs out");
    peek(`CFEF_OFS_LIVE, 8'h00, "hs gone");
    clr(`CFEF_OFS_STICKY);
  endtask : t_headset

  task automatic t_irq();
    int n;
    n = 0;
    irq_repeat = 1'b1;
    cond_in    = 8'h80;
    cyc(2);
    cond_in    = 8'h00;
    repeat (24) begin
      cyc(1);
      n += (irq_pulse === 1'b1) ? 1 : 0;
    end
    chk("irq on", (n >= 8) ? 8'h01 : 8'h00, 8'h01);
    clr(`CFEF_OFS_STICKY);
    cyc(10);
    n = 0;
    repeat (16) begin
      cyc(1);
      n += (irq_pulse === 1'b1) ? 1 : 0;
    end
    chk("irq off", 8'(n), 8'h00);
    irq_repeat = 1'b0;
  endtask : t_irq
  // ==========================================================
  // Main sequence
  initial begin
    num_errors  = 0;
    check_count = 0;
    sys_rst     = 1'b1;
    cond_in     = 8'h00;
    irq_repeat  = 1'b0;
    reg_rd      = 1'b0;
    reg_wr      = 1'b0;
    reg_addr    = 7'h00;
    cyc(5);
    sys_rst = 1'b0;
    cyc(1);
    peek(`CFEF_OFS_SHORT, 8'h00, "rst short");
    peek(`CFEF_OFS_STICKY, 8'h00, "rst sticky");
    peek(`CFEF_OFS_LIVE, 8'h00, "rst live");
    t_shorts();
    t_button();
    t_headset();
    t_irq();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
